//--- verilog/sahp_defs.svh
/*
 Constants of the stepper axis host port: reset values, byte select codes,
 command group codes and timing counts. Assumes a 100 MHz clock.
*/
// How it works
// - Step mode pin low selects full step, high selects half step sequencing.
// - General output follows bit 4 of the control mode command.
// - Interrupt output low on request, released by condition command, maskable.
// - Stop events raise interrupt when enabled by the start mode command.
// - Deceleration start raises interrupt when enabled by register select command.
// - Running output is low while the axis operates.
// - Reset held over three clocks; device settles within that time.
// - Strobes honoured only with chip select low; bus released otherwise.
// - Chip select and read low drive the addressed byte.
// - Write data captured on the rising edge of the write strobe.
// - Write byte select routes command, low, middle, high register bytes.
// - Read byte select returns status, then low, middle, high data bytes.
// - Upper address bits choose the axis on multi axis parts.
// - Axis codes 00 to 11 select first to fourth axis.
// - Reset clears internal registers zero to six.
// - Reset loads commands to 00, 40, 80 and c0 hex.
// - Reset phases are H L L H unipolar, H L L L bipolar; here reset loads H L L H, bipolar axes get H L L L two clocks after release.
// - Command byte with top bits 10 is a register select command.
`ifndef SAHP_DEFS_SVH
`define SAHP_DEFS_SVH
`define SAHP_SEL_CMD 2'h0
`define SAHP_SEL_LOW 2'h1
`define SAHP_SEL_MID 2'h2
`define SAHP_SEL_HIGH 2'h3
`define SAHP_GRP_START 2'h0
`define SAHP_GRP_CTRL 2'h1
`define SAHP_GRP_RSEL 2'h2
`define SAHP_GRP_OUT 2'h3
`define SAHP_RST_START 8'h00
`define SAHP_RST_CTRL 8'h40
`define SAHP_RST_RSEL 8'h80
`define SAHP_RST_OUT 8'hc0
`define SAHP_PH_UNI 4'h9
`define SAHP_PH_BI 4'h1
`define SAHP_CTRL_GOUT 4
`define SAHP_START_INTEN 5
`define SAHP_RSEL_INTEN 5
`define SAHP_OUT_INTACK 5
`define SAHP_PROC_CYCLES 2
`define SAHP_RST_MIN_CYCLES 3
`endif

//--- verilog/sahp_pkg.sv
/*
 Types of the stepper axis host port. Assumes sahp_defs.svh for constants.
*/
package sahp_pkg;
   // Host bus sampled each clock.
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [1:0] axis;
      logic [1:0] bsel;
      logic [7:0] data;
   } sahp_bus_t;
   // Motion core events of one axis.
   typedef struct packed {
      logic running;
      logic stopped;
      logic decel_start;
      logic step;
      logic dir;
   } sahp_evt_t;
   typedef enum logic [1:0] {
      SAHP_IDLE = 2'b00,
      SAHP_WRITE = 2'b01,
      SAHP_BUSY = 2'b10
   } sahp_wst_t;
endpackage

//--- verilog/sahp_top.sv
/*
 Host port of a multi axis stepper sequencer: 8-bit strobe bus, per axis
 command and data registers, interrupt, running, general output and phase
 outputs. Assumes host inputs synchronous to clk and a motion core that
 reports events per axis; pulse generation itself lives elsewhere.
*/
`include "sahp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sahp_top #(
   parameter int AXES = 4
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Host bus.
   input wire sahp_pkg::sahp_bus_t bus,
   output logic [7:0] data_out,
   output logic data_oe,
   // Per axis pins and core events.
   input wire logic [AXES-1:0] step_mode,
   input wire logic [AXES-1:0] drive_bipolar,
   input wire sahp_pkg::sahp_evt_t [AXES-1:0] evt,
   output logic int_n,
   output logic [AXES-1:0] running_n,
   output logic [AXES-1:0] general_output,
   output logic [AXES-1:0] pulse_out_n_pos,
   output logic [AXES-1:0] pulse_out_n_neg,
   output logic [AXES-1:0][3:0] phase
);
   import sahp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   logic sel;
   logic wr_prev;
   logic wr_rise;
   logic [1:0] ax;
   assign sel = !bus.cs_n;
   assign wr_rise = sel && bus.wr_n && !wr_prev;
   assign ax = (AXES > 1) ? bus.axis & 2'(AXES - 1) : 2'h0;

   // True when a write edge targets axis a at byte lane s.
   function automatic logic hit(input logic [1:0] a, input logic [1:0] s);
      hit = wr_rise && (ax == a) && (bus.bsel == s);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Per axis state.
   logic [AXES-1:0][7:0] cmd_start, cmd_ctrl, cmd_rsel, cmd_out;
   logic [AXES-1:0][23:0] data_reg [7];
   logic [AXES-1:0][23:0] hold;
   logic [AXES-1:0] irq, next_irq;
   logic [AXES-1:0][2:0] seq;
   logic [AXES-1:0] bip_latch;
   logic strap_take;

   genvar g;
   generate
      for (g = 0; g < AXES; g++) begin : g_axis
         logic [7:0] next_start, next_ctrl, next_rsel, next_out;
         logic [23:0] next_hold;
         logic [2:0] next_seq;
         logic [3:0] next_phase;
         logic [2:0] rn;
         // Command, data and interrupt next values.
         always_comb begin
            next_start = cmd_start[g];
            next_ctrl = cmd_ctrl[g];
            next_rsel = cmd_rsel[g];
            next_out = cmd_out[g];
            next_hold = hold[g];
            next_irq[g] = irq[g];
            if (hit(2'(g), `SAHP_SEL_CMD)) begin
               case (bus.data[7:6])
                  `SAHP_GRP_START: next_start = bus.data;
                  `SAHP_GRP_CTRL: next_ctrl = bus.data;
                  `SAHP_GRP_RSEL: next_rsel = bus.data;
                  default: next_out = bus.data;
               endcase
               // Acknowledge releases the interrupt line.
               if (bus.data[7:6] == `SAHP_GRP_OUT && bus.data[`SAHP_OUT_INTACK]) begin
                  next_irq[g] = 1'b0;
               end
            end
            if (hit(2'(g), `SAHP_SEL_LOW)) next_hold[7:0] = bus.data;
            if (hit(2'(g), `SAHP_SEL_MID)) next_hold[15:8] = bus.data;
            if (hit(2'(g), `SAHP_SEL_HIGH)) next_hold[23:16] = bus.data;
            // A new event wins over an acknowledge in the same cycle.
            if (evt[g].stopped && cmd_start[g][`SAHP_START_INTEN]) next_irq[g] = 1'b1;
            if (evt[g].decel_start && cmd_rsel[g][`SAHP_RSEL_INTEN]) next_irq[g] = 1'b1;
         end
         // Excitation step: half step walks all eight states, full step only odd ones.
         always_comb begin
            next_seq = seq[g];
            if (evt[g].step) begin
               if (step_mode[g]) next_seq = evt[g].dir ? seq[g] + 3'h1 : seq[g] - 3'h1;
               else next_seq = evt[g].dir ? (seq[g] | 3'h1) + 3'h2 : (seq[g] | 3'h1) - 3'h2;
            end
            case (next_seq)
               3'h0: next_phase = bip_latch[g] ? `SAHP_PH_BI : `SAHP_PH_UNI;
               3'h1: next_phase = 4'h3;
               3'h2: next_phase = 4'h2;
               3'h3: next_phase = 4'h6;
               3'h4: next_phase = 4'h4;
               3'h5: next_phase = 4'hc;
               3'h6: next_phase = 4'h8;
               default: next_phase = 4'h9;
            endcase
         end
         assign rn = cmd_rsel[g][2:0];
         // Registers; the data buffer moves to the selected register after a low byte write.
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cmd_start[g] <= `SAHP_RST_START;
               cmd_ctrl[g] <= `SAHP_RST_CTRL;
               cmd_rsel[g] <= `SAHP_RST_RSEL;
               cmd_out[g] <= `SAHP_RST_OUT;
               hold[g] <= 24'h000000;
               irq[g] <= 1'b0;
               seq[g] <= 3'h0;
               running_n[g] <= 1'b1;
               general_output[g] <= 1'b0;
               pulse_out_n_pos[g] <= 1'b1;
               pulse_out_n_neg[g] <= 1'b1;
               phase[g] <= `SAHP_PH_UNI;
               bip_latch[g] <= 1'b0;
               for (int r = 0; r < 7; r++) data_reg[r][g] <= 24'h000000;
            end else begin
               cmd_start[g] <= next_start;
               cmd_ctrl[g] <= next_ctrl;
               cmd_rsel[g] <= next_rsel;
               cmd_out[g] <= next_out;
               hold[g] <= next_hold;
               irq[g] <= next_irq[g];
               seq[g] <= next_seq;
               running_n[g] <= !evt[g].running;
               general_output[g] <= next_ctrl[`SAHP_CTRL_GOUT];
               pulse_out_n_pos[g] <= !(evt[g].step && evt[g].dir);
               pulse_out_n_neg[g] <= !(evt[g].step && !evt[g].dir);
               phase[g] <= next_phase;
               if (strap_take) bip_latch[g] <= drive_bipolar[g];
               if (hit(2'(g), `SAHP_SEL_LOW) && rn < 3'h7) data_reg[rn][g] <= next_hold;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Shared bus flops, read mux and interrupt output.
   logic [7:0] rd_byte;
   logic [23:0] rd_word;
   logic [2:0] rsel_ax;
   assign rsel_ax = cmd_rsel[ax][2:0];
   assign rd_word = (rsel_ax < 3'h7) ? data_reg[rsel_ax][ax] : 24'h000000;
   always_comb begin
      case (bus.bsel)
         `SAHP_SEL_CMD: rd_byte = {3'h0, irq[ax], !running_n[ax], rsel_ax};
         `SAHP_SEL_LOW: rd_byte = rd_word[7:0];
         `SAHP_SEL_MID: rd_byte = rd_word[15:8];
         default: rd_byte = rd_word[23:16];
      endcase
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_prev <= 1'b1;
         data_out <= 8'h00;
         data_oe <= 1'b0;
         int_n <= 1'b1;
         strap_take <= 1'b1;
      end else begin
         wr_prev <= bus.wr_n | bus.cs_n;
         data_oe <= sel && !bus.rd_n && bus.wr_n;
         data_out <= rd_byte;
         int_n <= !(|(next_irq));
         strap_take <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_bus_off;
      @(posedge clk) disable iff (rst) bus.cs_n |=> !data_oe;
   endproperty
   a_bus_off: assert property (p_bus_off) else $error("bus driven without chip select");
   property p_bus_on;
      @(posedge clk) disable iff (rst) (sel && !bus.rd_n && bus.wr_n) |=> data_oe;
   endproperty
   a_bus_on: assert property (p_bus_on) else $error("read not driven");
   property p_gout;
      @(posedge clk) disable iff (rst) general_output[0] == cmd_ctrl[0][`SAHP_CTRL_GOUT];
   endproperty
   a_gout: assert property (p_gout) else $error("general output wrong");
   property p_run;
      @(posedge clk) disable iff (rst) evt[0].running |=> !running_n[0];
   endproperty
   a_run: assert property (p_run) else $error("running output wrong");
   property p_stop_int;
      @(posedge clk) disable iff (rst)
         (evt[0].stopped && cmd_start[0][`SAHP_START_INTEN]) |=> !int_n;
   endproperty
   a_stop_int: assert property (p_stop_int) else $error("stop interrupt missing");
   // The line drops and the request is still held a cycle later.
   sequence s_dec_raised;
      !int_n ##1 irq[0];
   endsequence
   property p_dec_int;
      @(posedge clk) disable iff (rst)
         (evt[0].decel_start && cmd_rsel[0][`SAHP_RSEL_INTEN]) |=> s_dec_raised;
   endproperty
   a_dec_int: assert property (p_dec_int) else $error("decel interrupt missing");
   property p_rsel;
      @(posedge clk) disable iff (rst)
         (wr_rise && ax == 2'h0 && bus.bsel == 2'h0 && bus.data[7:6] == 2'h2)
         |=> cmd_rsel[0] == $past(bus.data);
   endproperty
   a_rsel: assert property (p_rsel) else $error("register select not taken");
   property p_ignore;
      @(posedge clk) disable iff (rst) bus.cs_n |=> $stable(hold[0]);
   endproperty
   a_ignore: assert property (p_ignore) else $error("write taken without chip select");
endmodule
`default_nettype wire

//--- tb/sahp_host.sv
/*
 Host processor model for the stepper axis host port: strobe bus cycles.
 Assumes the device answers a read within a few clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module sahp_host (
   // Clock.
   input wire logic clk,
   // Device answer.
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   // Host bus.
   output var sahp_pkg::sahp_bus_t bus
);
   import sahp_pkg::*;
   ////////////////////////////////////////
   // Idle bus; released data shows the inverse of the last value.
   initial begin
      bus = '{1'b1, 1'b1, 1'b1, 2'h0, 2'h0, 8'h5a};
   end
   // Write cycle; strobes never overlap, so no prohibited combination.
   task automatic wr(input logic cs_n, input logic [1:0] ax, input logic [1:0] bs,
         input logic [7:0] d);
      @(negedge clk);
      bus = '{cs_n, 1'b1, 1'b0, ax, bs, d};
      @(negedge clk);
      bus.wr_n = 1'b1;
      @(negedge clk);
      bus = '{1'b1, 1'b1, 1'b1, ax, bs, ~d};
      // The device digests a data byte before the next write.
      repeat (2) @(negedge clk);
   endtask
   // Read cycle; held until the device drives or a short limit runs out.
   task automatic rd(input logic cs_n, input logic [1:0] ax, input logic [1:0] bs,
         output logic [7:0] q, output logic oe);
      int n;
      @(negedge clk);
      bus = '{cs_n, 1'b0, 1'b1, ax, bs, ~bus.data};
      n = 0;
      while (data_oe !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      q = data_out;
      oe = data_oe;
      bus = '{1'b1, 1'b1, 1'b1, ax, bs, ~bus.data};
      repeat (2) @(negedge clk);
   endtask
endmodule
`default_nettype wire

//--- tb/stepper_axis_host_port_tb.sv
/*
 Testbench of the stepper axis host port: reset values, byte and axis
 decode, chip select, interrupt, running and general output.
 Assumes sahp_host drives the bus and events are driven here.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module stepper_axis_host_port_tb;
   import sahp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   sahp_bus_t bus;
   logic [7:0] data_out, q;
   logic data_oe, int_n, oe;
   logic [3:0] step_mode, drive_bipolar, running_n, general_output, pos_n, neg_n;
   sahp_evt_t [3:0] evt;
   logic [3:0][3:0] phase;
   int compares = 0;
   int miscompares = 0;
   int cycles = 0;
   ////////////////////////////////////////
   sahp_host host_u (.clk(clk), .data_out(data_out), .data_oe(data_oe), .bus(bus));
   sahp_top dut_u (.clk(clk), .rst(rst), .bus(bus), .data_out(data_out),
      .data_oe(data_oe), .step_mode(step_mode), .drive_bipolar(drive_bipolar),
      .evt(evt), .int_n(int_n), .running_n(running_n), .general_output(general_output),
      .pulse_out_n_pos(pos_n), .pulse_out_n_neg(neg_n), .phase(phase));
   // Free running clock.
   always #5 clk = ~clk;
   // Hang guard; the whole run needs well under a thousand cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////
   task automatic report_and_stop();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Selected read that must be driven with the expected byte.
   task automatic rchk(input logic [1:0] ax, input logic [1:0] bs, input logic [7:0] e);
      host_u.rd(1'b0, ax, bs, q, oe);
      `CHK(oe, 1'b1)
      `CHK(q, e)
   endtask
   // One cycle event pulse on one axis, then time to settle.
   task automatic pulse(input int a, input logic [4:0] e);
      @(negedge clk);
      evt[a] = sahp_evt_t'(e);
      @(negedge clk);
      evt[a] = '0;
      repeat (2) @(negedge clk);
   endtask
   ////////////////////////////////////////
   // Main sequence.
   initial begin
      step_mode = 4'h3;
      drive_bipolar = 4'h5;
      evt = '0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      `CHK({int_n, running_n, general_output, pos_n, neg_n, data_oe}, 18'h3e1fe)
      for (int a = 0; a < 4; a++) begin
         `CHK(phase[a], drive_bipolar[a] ? 4'h1 : 4'h9)
         rchk(a[1:0], 2'h0, 8'h00);
         rchk(a[1:0], 2'h1, 8'h00);
         rchk(a[1:0], 2'h3, 8'h00);
         host_u.wr(1'b0, a[1:0], 2'h0, 8'h82);
         host_u.wr(1'b0, a[1:0], 2'h3, 8'h10 + 8'(a));
         host_u.wr(1'b0, a[1:0], 2'h2, 8'h20 + 8'(a));
         host_u.wr(1'b0, a[1:0], 2'h1, 8'h30 + 8'(a));
      end
      host_u.wr(1'b1, 2'h0, 2'h1, 8'hee);
      host_u.rd(1'b1, 2'h0, 2'h1, q, oe);
      `CHK(oe, 1'b0)
      for (int a = 0; a < 4; a++) begin
         rchk(a[1:0], 2'h1, 8'h30 + 8'(a));
         rchk(a[1:0], 2'h2, 8'h20 + 8'(a));
         rchk(a[1:0], 2'h3, 8'h10 + 8'(a));
         rchk(a[1:0], 2'h0, 8'h02);
      end
      // Stop interrupt enabled, raised, read in status, then acknowledged.
      host_u.wr(1'b0, 2'h0, 2'h0, 8'h20);
      pulse(0, 5'h08);
      `CHK(int_n, 1'b0)
      rchk(2'h0, 2'h0, 8'h12);
      host_u.wr(1'b0, 2'h0, 2'h0, 8'he0);
      `CHK(int_n, 1'b1)
      host_u.wr(1'b0, 2'h0, 2'h0, 8'h00);
      pulse(0, 5'h08);
      `CHK(int_n, 1'b1)
      host_u.wr(1'b0, 2'h0, 2'h0, 8'ha2);
      pulse(0, 5'h04);
      `CHK(int_n, 1'b0)
      host_u.wr(1'b0, 2'h0, 2'h0, 8'he0);
      `CHK(int_n, 1'b1)
      // Running level on the third axis only.
      evt[2] = sahp_evt_t'(5'h10);
      repeat (2) @(negedge clk);
      `CHK(running_n, 4'hb)
      rchk(2'h2, 2'h0, 8'h0a);
      evt[2] = '0;
      repeat (2) @(negedge clk);
      `CHK(running_n, 4'hf)
      // One forward step on a half step axis and on a full step axis.
      @(negedge clk);
      evt[0] = sahp_evt_t'(5'h03);
      evt[2] = sahp_evt_t'(5'h03);
      @(negedge clk);
      evt[0] = '0;
      evt[2] = '0;
      `CHK({pos_n, neg_n}, 8'haf)
      `CHK(phase[0] != phase[2], 1'b1)
      @(negedge clk);
      `CHK({pos_n, neg_n}, 8'hff)
      host_u.wr(1'b0, 2'h1, 2'h0, 8'h50);
      `CHK(general_output, 4'h2)
      host_u.wr(1'b0, 2'h1, 2'h0, 8'h40);
      `CHK(general_output, 4'h0)
      host_u.wr(1'b0, 2'h1, 2'h0, 8'h50);
      // A second reset in mid-run must restore the initial state.
      rst = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(general_output, 4'h0)
      rchk(2'h1, 2'h1, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
